// [hw/boot_cfg_consts.svh]
// addresses, field positions and codes of the configuration words
// assumes byte addressing on the boot flash read port
`ifndef BOOT_CFG_CONSTS_SVH
`define BOOT_CFG_CONSTS_SVH

`define CFG_WORD_ZERO_ADDR   32'hBFC02FFC
`define CFG_WORD_ONE_ADDR    32'hBFC02FF8
`define CFG_WORD_TWO_ADDR    32'hBFC02FF4
`define CFG_WORD_THREE_ADDR  32'hBFC02FF0
`define PART_REV_ID_ADDR     32'hBF80F220
`define CFG_WORD_COUNT       3'h4
`define CFG_LAST_INDEX       2'h3
`define CFG_ERASED_WORD      32'hFFFFFFFF
`define UNMAPPED_READ        32'h00000000

// word one
`define WATCHDOG_FORCE_BIT   23
`define WATCHDOG_PS_LSB      16
`define WATCHDOG_PS_MAX      5'h14
`define CKSM_LSB             14
`define PBDIV_LSB            12
`define CLKOUT_EN_BIT        10
`define POSC_MODE_LSB        8
`define TWO_SPEED_BIT        7
`define SECONDARY_OSC_EN_BIT 5
`define INIT_OSC_LSB         0
// word two
`define PLL_ODIV_LSB         16
`define USB_PLL_EN_BIT       15
`define USB_PLL_IDIV_LSB     8
`define PLL_MULT_LSB         4
`define PLL_IDIV_LSB         0
// word three
`define BUS_POWER_OWN_BIT    31
`define USB_ID_OWN_BIT       30
`define CAN_PINS_BIT         26
`define ETH_PINS_BIT         25
`define ETH_FULL_IF_BIT      24
`define USER_ID_LSB          0

`endif

// [hw/boot_cfg_pkg.sv]
// types shared by the configuration loader and its field decoder
// constants live in boot_cfg_consts.svh
package boot_cfg_pkg;

  typedef logic [3:0][31:0] cfg_words_t;

  typedef enum logic [1:0]
  {
    LD_ADDR = 2'h0,
    LD_READ = 2'h1,
    LD_DONE = 2'h3
  } load_state_e;

  typedef enum logic [1:0]
  {
    POSC_EXTERNAL = 2'h0,
    POSC_STD_XTAL = 2'h1,
    POSC_HI_XTAL  = 2'h2,
    POSC_OFF      = 2'h3
  } posc_mode_e;

  typedef enum logic [2:0]
  {
    OSC_FAST_RC      = 3'h0,
    OSC_RC_DIV_PLL   = 3'h1,
    OSC_PRIMARY      = 3'h2,
    OSC_PRIMARY_PLL  = 3'h3,
    OSC_SECONDARY    = 3'h4,
    OSC_LOW_POWER_RC = 3'h5,
    OSC_RESERVED     = 3'h6,
    OSC_RC_DIVIDED   = 3'h7
  } init_osc_e;

  typedef struct packed {
    logic        watchdog_force_on;
    logic        watchdog_sw_may_enable;
    logic [4:0]  watchdog_postscale_log2;
    logic [20:0] watchdog_postscale_ratio;
    logic        clock_switch_enable;
    logic        fail_safe_monitor_enable;
    logic [3:0]  periph_bus_divisor;
    logic        clock_output_active;
    posc_mode_e  primary_osc_mode;
    logic        two_speed_startup_enable;
    logic        secondary_osc_enable;
    init_osc_e   initial_osc_select;
    logic [8:0]  pll_output_postscaler;
    logic        usb_pll_enable;
    logic        usb_pll_bypass;
    logic [3:0]  usb_pll_input_divider;
    logic [4:0]  pll_multiplier;
    logic [3:0]  pll_input_divider;
    logic        bus_power_pin_owner;
    logic        usb_id_pin_owner;
    logic        can_pin_set_sel;
    logic        ethernet_pin_set_sel;
    logic        ethernet_full_interface_sel;
    logic [15:0] user_identifier;
  } cfg_decoded_s;

endpackage

// [hw/cfg_field_decoder.sv]
// combinational decode of configuration words one to three into settings
// assumes the words are stable while the result is sampled
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module cfg_field_decoder
(
  // configuration words, index 0 is word zero
  input  wire boot_cfg_pkg::cfg_words_t   i_words,
  // decoded settings
  output boot_cfg_pkg::cfg_decoded_s      o_dec
);

  function automatic logic [3:0] in_div(input logic [2:0] code);
    unique case (code)
      3'h6:    in_div = 4'hA;
      3'h7:    in_div = 4'hC;
      default: in_div = 4'(code) + 4'h1;
    endcase
  endfunction

  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [4:0]  ps_code;
  logic [4:0]  ps_log2;
  logic [1:0]  cksm;
  logic [1:0]  pbdiv;
  logic [2:0]  odiv;
  logic [2:0]  mult;

  assign w1      = i_words[1];
  assign w2      = i_words[2];
  assign w3      = i_words[3];
  assign ps_code = w1[`WATCHDOG_PS_LSB +: 5];
  assign cksm    = w1[`CKSM_LSB +: 2];
  assign pbdiv   = w1[`PBDIV_LSB +: 2];
  assign odiv    = w2[`PLL_ODIV_LSB +: 3];
  assign mult    = w2[`PLL_MULT_LSB +: 3];
  // undefined postscale codes behave as the largest one
  assign ps_log2 = (ps_code > `WATCHDOG_PS_MAX) ? `WATCHDOG_PS_MAX
                   : ps_code;

  always_comb
  begin
    o_dec.watchdog_force_on        = w1[`WATCHDOG_FORCE_BIT];
    o_dec.watchdog_sw_may_enable   = ~w1[`WATCHDOG_FORCE_BIT];
    o_dec.watchdog_postscale_log2  = ps_log2;
    o_dec.watchdog_postscale_ratio = 21'h000001 << ps_log2;
    o_dec.clock_switch_enable      = ~cksm[1];
    o_dec.fail_safe_monitor_enable = (cksm == 2'h0);
    o_dec.periph_bus_divisor       = 4'h1 << pbdiv;
    o_dec.clock_output_active      = w1[`CLKOUT_EN_BIT]
      && (w1[`POSC_MODE_LSB +: 2] == 2'h3
          || w1[`POSC_MODE_LSB +: 2] == 2'h0);
    o_dec.primary_osc_mode         =
      boot_cfg_pkg::posc_mode_e'(w1[`POSC_MODE_LSB +: 2]);
    o_dec.two_speed_startup_enable = w1[`TWO_SPEED_BIT];
    o_dec.secondary_osc_enable     = w1[`SECONDARY_OSC_EN_BIT];
    o_dec.initial_osc_select       =
      boot_cfg_pkg::init_osc_e'(w1[`INIT_OSC_LSB +: 3]);
    o_dec.pll_output_postscaler    = (odiv == 3'h7) ? 9'h100
                                     : 9'h001 << odiv;
    o_dec.usb_pll_enable           = w2[`USB_PLL_EN_BIT];
    o_dec.usb_pll_bypass           = ~w2[`USB_PLL_EN_BIT];
    o_dec.usb_pll_input_divider    =
      in_div(w2[`USB_PLL_IDIV_LSB +: 3]);
    o_dec.pll_input_divider        = in_div(w2[`PLL_IDIV_LSB +: 3]);
    o_dec.pll_multiplier           = (mult == 3'h7) ? 5'h18
                                     : 5'h0F + 5'(mult);
    o_dec.bus_power_pin_owner      = w3[`BUS_POWER_OWN_BIT];
    o_dec.usb_id_pin_owner         = w3[`USB_ID_OWN_BIT];
    o_dec.can_pin_set_sel          = w3[`CAN_PINS_BIT];
    o_dec.ethernet_pin_set_sel     = w3[`ETH_PINS_BIT];
    o_dec.ethernet_full_interface_sel = w3[`ETH_FULL_IF_BIT];
    o_dec.user_identifier          = w3[`USER_ID_LSB +: 16];
  end

endmodule // cfg_field_decoder

// [hw/boot_config_word_loader.sv]
// boot configuration loader: copies four words from boot flash into
// volatile registers, decodes and holds them, answers the programmer.
// assumes flash and programmer ports run on i_sys_clk.
// assumes a power-on reset with i_rst_is_por before the first write.
// What this block does
// - every reset reloads all four words from flash
// - words sit at top four boot flash words
// - programming only clears bits; erased reads one
// - watchdog force bit: forced on, else optional
// - postscale ratio is two to the code
// - postscale codes above 10100 act as 10100
// - switch/monitor field: 1x off, 01, 00
// - peripheral bus divisor 1, 2, 4, 8
// - clock output only with oscillator mode 11/00
// - primary oscillator mode decode
// - switch-over bit enables two-speed start-up
// - secondary oscillator enable bit
// - initial oscillator select decode
// - PLL postscaler 1 to 64, then 256
// - USB PLL enable, else disabled and bypassed
// - both input dividers 1,2,3,4,5,6,10,12
// - PLL multiplier 15 to 21, then 24
// - pin ownership bits for USB, CAN, Ethernet
// - Ethernet full or reduced interface select
// - user identifier and part/revision register readable
// - written bits locked until power cycles
// - words checked against complements, mismatch resets
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module boot_config_word_loader #(
  // arbitrary values, not any real part
  parameter logic [3:0]  REVISION_ID = 4'h1,
  parameter logic [27:0] DEVICE_CODE = 28'h0000001
)
(
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_rst_is_por,
  // boot flash read port
  output logic                            o_flash_req,
  output logic [31:0]                     o_flash_addr,
  input  wire logic                       i_flash_valid,
  input  wire logic [31:0]                i_flash_rdata,
  // programmer access
  input  wire logic                       i_prog_rd,
  input  wire logic                       i_prog_wr,
  input  wire logic [31:0]                i_prog_addr,
  input  wire logic [31:0]                i_prog_wdata,
  output logic [31:0]                     o_prog_rdata,
  output logic                            o_prog_rvalid,
  // decoded settings to clock, watchdog and pin logic
  output boot_cfg_pkg::cfg_decoded_s      o_cfg,
  output logic                            o_cfg_valid,
  output logic                            o_cfg_mismatch_rst
);

  // loader state
  boot_cfg_pkg::load_state_e  state_reg;
  boot_cfg_pkg::load_state_e  state_next;
  logic [1:0]                 idx_reg;
  logic [1:0]                 idx_next;
  logic [31:0]                addr_reg;
  logic [31:0]                addr_next;

  // volatile words, complements and write locks
  boot_cfg_pkg::cfg_words_t   words_reg;
  boot_cfg_pkg::cfg_words_t   words_next;
  boot_cfg_pkg::cfg_words_t   cmpl_reg;
  boot_cfg_pkg::cfg_words_t   cmpl_next;
  logic [3:0]                 lock_reg;
  logic [3:0]                 lock_next;

  // held outputs
  boot_cfg_pkg::cfg_decoded_s cfg_reg;
  boot_cfg_pkg::cfg_decoded_s cfg_next;
  boot_cfg_pkg::cfg_decoded_s dec;
  logic                       valid_reg;
  logic                       valid_next;
  logic                       mism_reg;
  logic                       mism_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic                       rvalid_reg;
  logic                       rvalid_next;

  logic [3:0]                 word_bad;
  logic [3:0]                 prog_hit;
  logic [31:0]                hit_addr [4];

  // programmer request decode
  logic                       wr_open;
  logic [3:0]                 wr_ok;
  logic                       id_hit;
  logic                       any_bad;

  assign hit_addr[0] = `CFG_WORD_ZERO_ADDR;
  assign hit_addr[1] = `CFG_WORD_ONE_ADDR;
  assign hit_addr[2] = `CFG_WORD_TWO_ADDR;
  assign hit_addr[3] = `CFG_WORD_THREE_ADDR;

  // writes count only once the copy from flash is complete
  assign wr_open = i_prog_wr && (state_reg == boot_cfg_pkg::LD_DONE);
  assign id_hit  = (i_prog_addr == `PART_REV_ID_ADDR);
  assign any_bad = |word_bad;

  cfg_field_decoder u_dec
  (
    .i_words (words_reg),
    .o_dec   (dec)
  );

  // per word: address match and complement check
  genvar w;
  generate
    for (w = 0; w < 4; w++)
    begin : g_word
      assign prog_hit[w] = (i_prog_addr == hit_addr[w]);
      // each stored bit must differ from its complement copy
      assign word_bad[w] = |(words_reg[w] ~^ cmpl_reg[w]);
      // one write per word per power cycle, then locked
      assign wr_ok[w]    = wr_open && prog_hit[w] && !lock_reg[w];
    end
  endgenerate

  // loader: step down from word zero to word three
  // no time limit: a silent flash leaves the settings invalid
  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    addr_next  = addr_reg;
    if (i_rst)
    begin
      // any reset restarts the copy from word zero
      state_next = boot_cfg_pkg::LD_ADDR;
      idx_next   = 2'h0;
      addr_next  = `CFG_WORD_ZERO_ADDR;
    end
    else
    begin
      unique case (state_reg)
        boot_cfg_pkg::LD_ADDR:
        begin
          addr_next  = hit_addr[idx_reg];
          state_next = boot_cfg_pkg::LD_READ;
        end
        boot_cfg_pkg::LD_READ:
        begin
          if (i_flash_valid)
          begin
            if (idx_reg == `CFG_LAST_INDEX)
            begin
              state_next = boot_cfg_pkg::LD_DONE;
            end
            else
            begin
              idx_next   = idx_reg + 2'h1;
              state_next = boot_cfg_pkg::LD_ADDR;
            end
          end
        end
        boot_cfg_pkg::LD_DONE:
        begin
          state_next = boot_cfg_pkg::LD_DONE;
        end
        default:
        begin
          state_next = boot_cfg_pkg::LD_ADDR;
          idx_next   = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    state_reg <= state_next;
    idx_reg   <= idx_next;
    addr_reg  <= addr_next;
  end

  // storage: flash copy, programmer writes, locks
  always_comb
  begin
    words_next = words_reg;
    cmpl_next  = cmpl_reg;
    lock_next  = lock_reg;
    if (i_rst)
    begin
      // erased state until the flash copy lands
      words_next = {4{`CFG_ERASED_WORD}};
      cmpl_next  = {4{~`CFG_ERASED_WORD}};
      // only a power cycle frees written words
      if (i_rst_is_por)
      begin
        lock_next = 4'h0;
      end
    end
    else if (state_reg == boot_cfg_pkg::LD_READ && i_flash_valid)
    begin
      words_next[idx_reg] = i_flash_rdata;
      cmpl_next[idx_reg]  = ~i_flash_rdata;
    end
    else if (wr_open)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (wr_ok[k])
        begin
          // and-only: a one can be cleared, a zero never set
          words_next[k] = words_reg[k] & i_prog_wdata;
          cmpl_next[k]  = ~(words_reg[k] & i_prog_wdata);
          lock_next[k]  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    words_reg <= words_next;
    cmpl_reg  <= cmpl_next;
    lock_reg  <= lock_next;
  end

  // settings snapshot taken once, the cycle after the last word arrives
  always_comb
  begin
    cfg_next   = cfg_reg;
    valid_next = valid_reg;
    mism_next  = 1'b0;
    if (i_rst)
    begin
      cfg_next   = '0;
      valid_next = 1'b0;
    end
    else
    begin
      if (state_reg == boot_cfg_pkg::LD_DONE && !valid_reg)
      begin
        // later programmer writes do not reach the consumers
        cfg_next   = dec;
        valid_next = 1'b1;
      end
      // held until reset clears the fault
      mism_next = mism_reg || any_bad;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    cfg_reg   <= cfg_next;
    valid_reg <= valid_next;
    mism_reg  <= mism_next;
  end

  // programmer read port, one cycle latency
  always_comb
  begin
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (i_rst)
    begin
      rdata_next = `UNMAPPED_READ;
    end
    else if (i_prog_rd)
    begin
      rvalid_next = 1'b1;
      rdata_next  = `UNMAPPED_READ;
      for (int k = 0; k < 4; k++)
      begin
        if (prog_hit[k])
        begin
          rdata_next = words_reg[k];
        end
      end
      if (id_hit)
      begin
        rdata_next = {REVISION_ID, DEVICE_CODE};
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    rdata_reg  <= rdata_next;
    rvalid_reg <= rvalid_next;
  end

  assign o_flash_req        = (state_reg == boot_cfg_pkg::LD_READ);
  assign o_flash_addr       = addr_reg;
  assign o_prog_rdata       = rdata_reg;
  assign o_prog_rvalid      = rvalid_reg;
  assign o_cfg              = cfg_reg;
  assign o_cfg_valid        = valid_reg;
  assign o_cfg_mismatch_rst = mism_reg;

endmodule // boot_config_word_loader

// [sim/boot_cfg_asserts.sv]
// checker for the configuration loader, bound to every instance
// assumes one clock domain and the constants header on the path
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module boot_cfg_checker #(
  parameter logic [3:0]  REVISION_ID = 4'h1,
  parameter logic [27:0] DEVICE_CODE = 28'h0000001
)
(
  // clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst,
  // flash port
  input  wire logic                        o_flash_req,
  input  wire logic [31:0]                 o_flash_addr,
  input  wire logic                        i_flash_valid,
  // programmer port
  input  wire logic                        i_prog_rd,
  input  wire logic                        i_prog_wr,
  input  wire logic [31:0]                 i_prog_addr,
  input  wire logic [31:0]                 o_prog_rdata,
  input  wire logic                        o_prog_rvalid,
  // settings
  input  wire boot_cfg_pkg::cfg_decoded_s  o_cfg,
  input  wire logic                        o_cfg_valid,
  input  wire logic                        o_cfg_mismatch_rst
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic mapped;
  logic took;
  assign mapped = i_prog_addr inside {`CFG_WORD_ZERO_ADDR,
    `CFG_WORD_ONE_ADDR, `CFG_WORD_TWO_ADDR, `CFG_WORD_THREE_ADDR,
    `PART_REV_ID_ADDR};
  assign took = o_flash_req && i_flash_valid;

  chk_word_order:
    assert property (took && o_flash_addr == `CFG_WORD_ZERO_ADDR |->
      ##[1:2] !o_flash_req ##1
      (o_flash_req && o_flash_addr == `CFG_WORD_ONE_ADDR))
    else $error("second flash word not read after first");
  chk_load_done:
    assert property (took && o_flash_addr == `CFG_WORD_THREE_ADDR |->
      ##[2:3] o_cfg_valid)
    else $error("settings not valid after last word");
  chk_cfg_hold:
    assert property (o_cfg_valid |=> o_cfg_valid && $stable(o_cfg))
    else $error("settings moved while valid");
  chk_cfg_zero:
    assert property (!o_cfg_valid |-> o_cfg == '0)
    else $error("settings nonzero before load");
  chk_rd_answer:
    assert property (i_prog_rd |=> o_prog_rvalid)
    else $error("read not answered next cycle");
  chk_rvalid_cause:
    assert property (o_prog_rvalid |-> $past(i_prog_rd))
    else $error("read answer without request");
  chk_id_value:
    assert property (i_prog_rd && i_prog_addr == `PART_REV_ID_ADDR |=>
      o_prog_rdata == {REVISION_ID, DEVICE_CODE})
    else $error("part id read wrong");
  chk_unmapped_zero:
    assert property (i_prog_rd && !mapped |=>
      o_prog_rdata == `UNMAPPED_READ)
    else $error("unmapped read not zero");
  chk_ps_ratio:
    assert property (o_cfg_valid |-> o_cfg.watchdog_postscale_log2
      <= `WATCHDOG_PS_MAX && o_cfg.watchdog_postscale_ratio ==
      21'h1 << o_cfg.watchdog_postscale_log2)
    else $error("postscale ratio wrong");
  chk_clkout_mode:
    assert property (o_cfg.clock_output_active |-> o_cfg.primary_osc_mode
      inside {boot_cfg_pkg::POSC_OFF, boot_cfg_pkg::POSC_EXTERNAL})
    else $error("clock output with crystal mode");
  chk_monitor_sw:
    assert property (o_cfg.fail_safe_monitor_enable |->
      o_cfg.clock_switch_enable)
    else $error("monitor without switching");
  chk_usb_bypass:
    assert property (o_cfg_valid |->
      o_cfg.usb_pll_bypass != o_cfg.usb_pll_enable)
    else $error("usb pll bypass wrong");
  chk_no_mismatch:
    assert property (!o_cfg_mismatch_rst)
    else $error("mismatch reset raised");

  cover property ($rose(o_cfg_valid));
  cover property (i_prog_wr && o_cfg_valid);
  cover property (o_cfg.clock_output_active);
endmodule // boot_cfg_checker

bind boot_config_word_loader boot_cfg_checker #(
  .REVISION_ID(REVISION_ID), .DEVICE_CODE(DEVICE_CODE)) u_chk (
  .i_sys_clk, .i_rst, .o_flash_req, .o_flash_addr, .i_flash_valid,
  .i_prog_rd, .i_prog_wr, .i_prog_addr, .o_prog_rdata, .o_prog_rvalid,
  .o_cfg, .o_cfg_valid, .o_cfg_mismatch_rst);

// [sim/boot_flash_model.sv]
// boot flash stand-in: answers one word per request after a set wait
// assumes the loader holds request and address until valid
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module boot_flash_model
(
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  // contents and answer delay
  input  wire boot_cfg_pkg::cfg_words_t  i_words,
  input  wire logic [1:0]                i_wait,
  // read port
  input  wire logic                      i_req,
  input  wire logic [31:0]               i_addr,
  output logic                           o_valid,
  output logic [31:0]                    o_rdata
);
  int         cnt;
  logic [1:0] idx;
  initial
  begin
    o_valid = 1'b0;
    o_rdata = 32'h0;
    cnt = 0;
  end
  always @(posedge i_sys_clk)
  begin
    #1;
    idx = 2'((`CFG_WORD_ZERO_ADDR - i_addr) >> 2);
    // stale data flips so it never passes for an answer
    o_rdata = ~o_rdata;
    // a gap after each answer, so one request gets one word
    if (i_rst || o_valid || !i_req)
    begin
      o_valid = 1'b0;
      cnt = 0;
    end
    else if (cnt >= i_wait)
    begin
      o_valid = 1'b1;
      o_rdata = i_words[idx];
    end
    else
      cnt++;
  end
endmodule // boot_flash_model

// [sim/tb.sv]
// self-checking bench for the configuration loader
// assumes the flash stand-in and checker are compiled with it
`timescale 1ns/1ps
`include "boot_cfg_consts.svh"

module tb;
  // arbitrary values, not any real part
  localparam logic [3:0]  REV = 4'h5;
  localparam logic [27:0] DEV = 28'h00000A5;
  logic                        i_sys_clk = 1'b0;
  logic                        i_rst = 1'b1;
  logic                        i_rst_is_por = 1'b1;
  logic                        i_prog_rd = 1'b0;
  logic                        i_prog_wr = 1'b0;
  logic [31:0]                 i_prog_addr = 32'h0;
  logic [31:0]                 i_prog_wdata = 32'h0;
  logic                        o_flash_req, i_flash_valid, o_prog_rvalid;
  logic                        o_cfg_valid, o_cfg_mismatch_rst;
  logic [31:0]                 o_flash_addr, i_flash_rdata, o_prog_rdata;
  boot_cfg_pkg::cfg_decoded_s  o_cfg;
  boot_cfg_pkg::cfg_words_t    fl = '1;
  logic [1:0]                  fl_wait = 2'h0;
  logic [31:0]                 vw [4];
  logic [3:0]                  lock = 4'h0;
  logic [31:0]                 rdv, wd, wa;
  integer                      seed = 32'h72fd;
  int                          fails = 0, comparisons = 0, k;

  boot_config_word_loader #(.REVISION_ID(REV), .DEVICE_CODE(DEV)) DUT (
    .i_sys_clk, .i_rst, .i_rst_is_por, .o_flash_req, .o_flash_addr,
    .i_flash_valid, .i_flash_rdata, .i_prog_rd, .i_prog_wr, .i_prog_addr,
    .i_prog_wdata, .o_prog_rdata, .o_prog_rvalid, .o_cfg, .o_cfg_valid,
    .o_cfg_mismatch_rst);
  boot_flash_model u_flash (.i_sys_clk, .i_rst, .i_words(fl),
    .i_wait(fl_wait), .i_req(o_flash_req), .i_addr(o_flash_addr),
    .o_valid(i_flash_valid), .o_rdata(i_flash_rdata));

  initial
    forever #12.5 i_sys_clk = ~i_sys_clk;

  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkcfg(boot_cfg_pkg::cfg_decoded_s e, g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] o_cfg expected %h seen %h", e, g);
    end
  endtask

  // settings as the words read, worked out independently
  function automatic boot_cfg_pkg::cfg_decoded_s dec(
    boot_cfg_pkg::cfg_words_t w);
    int         dv [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    logic [4:0] ps;
    ps = (w[1][20:16] > 5'h14) ? 5'h14 : w[1][20:16];
    return '{w[1][23], ~w[1][23], ps, 21'h1 << ps,
      ~w[1][15], w[1][15:14] == 2'h0, 4'h1 << w[1][13:12],
      w[1][10] && w[1][9:8] inside {2'h0, 2'h3},
      boot_cfg_pkg::posc_mode_e'(w[1][9:8]), w[1][7], w[1][5],
      boot_cfg_pkg::init_osc_e'(w[1][2:0]),
      (w[2][18:16] == 3'h7) ? 9'h100 : 9'h1 << w[2][18:16],
      w[2][15], ~w[2][15], 4'(dv[w[2][10:8]]),
      (w[2][6:4] == 3'h7) ? 5'h18 : 5'hF + w[2][6:4],
      4'(dv[w[2][2:0]]), w[3][31], w[3][30], w[3][26],
      w[3][25], w[3][24], w[3][15:0]};
  endfunction

  task automatic do_rst(input logic por);
    @(posedge i_sys_clk) #1;
    i_rst = 1'b1;
    i_rst_is_por = por;
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    i_rst_is_por = 1'b0;
    for (int j = 0; j < 4; j++)
      vw[j] = fl[j];
    if (por)
      lock = 4'h0;
    for (int j = 0; j < 200 && o_cfg_valid !== 1'b1; j++)
      @(posedge i_sys_clk) #1;
    if (o_cfg_valid !== 1'b1)
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_sys_clk) #1;
    i_prog_rd = 1'b1;
    i_prog_addr = a;
    @(posedge i_sys_clk) #1;
    i_prog_rd = 1'b0;
    chk32("o_prog_rvalid", 32'h1, {31'h0, o_prog_rvalid});
    d = o_prog_rdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_sys_clk) #1;
    i_prog_wr = 1'b1;
    i_prog_addr = a;
    i_prog_wdata = d;
    @(posedge i_sys_clk) #1;
    i_prog_wr = 1'b0;
  endtask

  initial
  begin
    do_rst(1'b1);
    for (int i = 0; i < 32; i++)
    begin
      // fresh page contents; codes swept by the loop index
      wd = $random(seed);
      fl[1] = (wd & ~32'h001FF307) | (i << 16) | (i[1:0] << 14)
        | (i[3:2] << 12) | (i[1:0] << 8) | i[2:0];
      wd = $random(seed);
      fl[2] = (wd & ~32'h00070777) | (i[2:0] << 16) | (i[2:0] << 8)
        | (i[2:0] << 4) | i[2:0];
      fl[0] = $random(seed);
      fl[3] = $random(seed);
      fl_wait = 2'($random(seed));
      do_rst(i % 4 == 0);
      chkcfg(dec(fl), o_cfg);
      for (k = 0; k < 4; k++)
      begin
        rd(`CFG_WORD_ZERO_ADDR - 32'(4 * k), rdv);
        chk32("config word", vw[k], rdv);
      end
      wr(`PART_REV_ID_ADDR, 32'h0);
      rd(`PART_REV_ID_ADDR, rdv);
      chk32("part id", {REV, DEV}, rdv);
      rd(`CFG_WORD_ZERO_ADDR + 32'h4, rdv);
      chk32("unmapped", `UNMAPPED_READ, rdv);
      k = i % 4;
      wa = `CFG_WORD_ZERO_ADDR - 32'(4 * k);
      repeat (2)
      begin
        wd = $random(seed);
        wr(wa, wd);
        // only clears bits, and only the first write counts
        if (!lock[k])
          vw[k] &= wd;
        lock[k] = 1'b1;
        rd(wa, rdv);
        chk32("written word", vw[k], rdv);
      end
      chkcfg(dec(fl), o_cfg);
      chk32("mismatch", 32'h0, {31'h0, o_cfg_mismatch_rst});
    end
    test_done();
  end
endmodule // tb
